// ==== verilog/chap_pkg.sv ====
// Package of constants for the card host address and status pin block
package chap_pkg;
  // Interface modes
  typedef enum logic [1:0] {
    CHAP_MODE_MEMORY = 2'b00,
    CHAP_MODE_IO = 2'b01,
    CHAP_MODE_DISK = 2'b10
  } chap_mode_type;

  // Decode targets
  typedef enum logic [2:0] {
    CHAP_SEL_NONE = 3'b000,
    CHAP_SEL_IO_PORT = 3'b001,
    CHAP_SEL_MEM_PORT = 3'b010,
    CHAP_SEL_CIS = 3'b011,
    CHAP_SEL_CONFIG = 3'b100,
    CHAP_SEL_TASK_FILE = 3'b101
  } chap_sel_type;

  localparam int CHAP_ADDR_W = 11;
  localparam int CHAP_TASK_W = 3;
  // Attribute space split: CIS below this, config registers at and above
  localparam logic [10:0] CHAP_CONFIG_BASE = 11'h200;
  // Card config and status register: alert enable bit position
  localparam int CHAP_CSR_ALERT_EN_BIT = 6;
  localparam logic [7:0] CHAP_CSR_RESET = 8'h00;
endpackage : chap_pkg

// ==== verilog/chap_sync.sv ====
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module chap_sync #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_r;

  // Only the second stage reads the first
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta_r <= '0;
      sync_o <= '0;
    end else begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end
endmodule // chap_sync
`default_nettype wire

// ==== verilog/chap_top.sv ====
// Address decode and status pins of the card host port
`timescale 1ns/10ps
`default_nettype none
module chap_top
  import chap_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic [1:0] mode_i,
  input wire logic [10:0] addr_i,
  input wire logic attr_sel_n_i,
  input wire logic chip_enable_low_byte_n_i,
  input wire logic chip_enable_high_byte_n_i,
  input wire logic ready_i,
  input wire logic write_protect_i,
  input wire logic [7:0] card_csr_i,
  input wire logic pass_diag_drive_i,
  input wire logic status_pin_i,
  output logic [2:0] reg_sel_o,
  output logic [10:0] reg_addr_o,
  output logic word_odd_warn_o,
  output logic byte_lane_low_only_o,
  output logic status_pin_o,
  output logic status_pin_oe_o,
  output logic pass_diagnostic_n_o,
  output logic battery_volt_detect_two_o,
  output logic battery_volt_detect_two_oe_o
);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [16:0] pins_s;
  logic [10:0] addr_s;
  logic attr_n_s, ce_lo_n_s, ce_hi_n_s, ready_s, wp_s, diag_s;

  chap_sync #(.WIDTH(17)) u_sync (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .async_i({addr_i, attr_sel_n_i, chip_enable_low_byte_n_i,
              chip_enable_high_byte_n_i, ready_i, write_protect_i,
              status_pin_i}),
    .sync_o(pins_s)
  );
  assign {addr_s, attr_n_s, ce_lo_n_s, ce_hi_n_s, ready_s, wp_s, diag_s} =
    pins_s;

  chap_mode_type mode;
  assign mode = chap_mode_type'(mode_i);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic chap_sel_type chap_decode(input chap_mode_type m,
                                               input logic attr_n,
                                               input logic [10:0] a);
    chap_sel_type s;
    s = CHAP_SEL_NONE;
    case (m)
      CHAP_MODE_DISK: s = CHAP_SEL_TASK_FILE;
      CHAP_MODE_IO: begin
        if (!attr_n) begin
          s = (a >= CHAP_CONFIG_BASE) ? CHAP_SEL_CONFIG : CHAP_SEL_CIS;
        end else begin
          s = CHAP_SEL_IO_PORT;
        end
      end
      CHAP_MODE_MEMORY: begin
        if (!attr_n) begin
          s = (a >= CHAP_CONFIG_BASE) ? CHAP_SEL_CONFIG : CHAP_SEL_CIS;
        end else begin
          s = CHAP_SEL_MEM_PORT;
        end
      end
      default: s = CHAP_SEL_NONE;
    endcase
    return s;
  endfunction

  logic selected;
  assign selected = !ce_lo_n_s || !ce_hi_n_s;

  // Outputs registered one cycle after the synchronised pins
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_sel_o <= CHAP_SEL_NONE;
      reg_addr_o <= 11'h000;
    end else if (!selected) begin
      reg_sel_o <= CHAP_SEL_NONE;
      reg_addr_o <= 11'h000;
    end else if (mode == CHAP_MODE_DISK) begin
      // Upper lines ignored even if the host leaves them high
      reg_sel_o <= chap_decode(mode, attr_n_s, addr_s);
      reg_addr_o <= {8'h00, addr_s[CHAP_TASK_W-1:0]};
    end else begin
      reg_sel_o <= chap_decode(mode, attr_n_s, addr_s);
      reg_addr_o <= addr_s;
    end
  end

  // Flags the word access with odd address that cards mishandle
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      word_odd_warn_o <= 1'b0;
    end else begin
      word_odd_warn_o <= (mode != CHAP_MODE_DISK) && !ce_lo_n_s &&
                         !ce_hi_n_s && addr_s[0];
    end
  end

  // Task file is byte wide on the low lane in disk mode
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      byte_lane_low_only_o <= 1'b0;
    end else begin
      byte_lane_low_only_o <= (mode == CHAP_MODE_DISK) && selected;
    end
  end

  // ----------------------------------------------------------------
  // Status change alert
  // ----------------------------------------------------------------
  logic ready_r, wp_r, alert_r, alert_nxt;
  logic alert_en;
  logic [2:0] settle_r;
  assign alert_en = card_csr_i[CHAP_CSR_ALERT_EN_BIT];
  assign alert_nxt = settle_r[2] && (mode == CHAP_MODE_IO) && alert_en &&
                     ((ready_s != ready_r) || (wp_s != wp_r));

  // Synchronisers and history start at zero, not at the pin levels, so a
  // high ready pin would fake a change; compare only once all are loaded
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      settle_r <= 3'h0;
    end else begin
      settle_r <= {settle_r[1:0], 1'b1};
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ready_r <= 1'b0;
      wp_r <= 1'b0;
      alert_r <= 1'b0;
    end else begin
      ready_r <= ready_s;
      wp_r <= wp_s;
      alert_r <= alert_nxt;
    end
  end

  logic diag_r;
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      diag_r <= 1'b0;
    end else begin
      diag_r <= pass_diag_drive_i;
    end
  end

  // Shared pin: battery detect, alert, or pass diagnostic by mode
  always_comb begin
    status_pin_o = 1'b1;
    status_pin_oe_o = 1'b1;
    case (mode)
      CHAP_MODE_MEMORY: status_pin_o = 1'b1;
      CHAP_MODE_IO: status_pin_o = !alert_r;
      CHAP_MODE_DISK: begin
        // Open-drain style so the partner drive can also pull low
        status_pin_o = 1'b0;
        status_pin_oe_o = diag_r;
      end
      default: status_pin_o = 1'b1;
    endcase
  end

  assign pass_diagnostic_n_o = (mode == CHAP_MODE_DISK) ? diag_s : 1'b1;

  // Battery status not implemented, so held high
  assign battery_volt_detect_two_o = 1'b1;
  assign battery_volt_detect_two_oe_o = (mode == CHAP_MODE_MEMORY);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_bvd_one_high: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    mode == CHAP_MODE_MEMORY |-> status_pin_o && status_pin_oe_o)
    else $error("first battery detect not high");
  a_bvd_two_high: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    battery_volt_detect_two_o)
    else $error("second battery detect not high");
  a_task_upper_zero: assert property (@(posedge core_clk_i)
    disable iff (!rst_b_i)
    (mode == CHAP_MODE_DISK && selected) ##1 $stable(mode)
      |-> reg_addr_o[10:3] == 8'h00 && reg_sel_o == CHAP_SEL_TASK_FILE)
    else $error("task file decode used upper bits");
  a_card_addr_pass: assert property (@(posedge core_clk_i)
    disable iff (!rst_b_i)
    (mode != CHAP_MODE_DISK && selected) ##1 $stable(mode)
      |-> reg_addr_o == $past(addr_s))
    else $error("card mode address not decoded");
  a_attr_decode: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (mode == CHAP_MODE_IO && selected && !attr_n_s) ##1 $stable(mode)
      |-> reg_sel_o inside {CHAP_SEL_CIS, CHAP_SEL_CONFIG})
    else $error("attribute select not honoured");
  a_alert_on_change: assert property (@(posedge core_clk_i)
    disable iff (!rst_b_i)
    (settle_r[2] && mode == CHAP_MODE_IO && alert_en && $changed(ready_s))
      ##1 (mode == CHAP_MODE_IO) |-> !status_pin_o)
    else $error("alert missed ready change");
  a_alert_masked: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (!alert_en ##1 mode == CHAP_MODE_IO) |-> status_pin_o)
    else $error("alert driven while disabled");
  a_diag_release: assert property (@(posedge core_clk_i)
    disable iff (!rst_b_i)
    (mode == CHAP_MODE_DISK && !pass_diag_drive_i) ##1
      (mode == CHAP_MODE_DISK) |-> !status_pin_oe_o)
    else $error("pass diagnostic driven while released");
  a_word_odd_flag: assert property (@(posedge core_clk_i)
    disable iff (!rst_b_i)
    (mode != CHAP_MODE_DISK && !ce_lo_n_s && !ce_hi_n_s && addr_s[0])
      ##1 (mode != CHAP_MODE_DISK) |-> word_odd_warn_o)
    else $error("odd word access not flagged");
  a_low_lane_disk: assert property (@(posedge core_clk_i)
    disable iff (!rst_b_i)
    (mode == CHAP_MODE_DISK && selected) |=> byte_lane_low_only_o)
    else $error("disk register access not low lane");
endmodule // chap_top
`default_nettype wire

// ==== verification/chap_host_model.sv ====
// Host-side model of the shared status pin with its pull-up
`timescale 1ns/10ps
`default_nettype none
module chap_host_model (
  input wire logic drv_i,
  input wire logic drv_oe_i,
  input wire logic peer_pull_n_i,
  output logic pin_level_o
);
  // ----------------------------------------
  // Wire resolution
  // ----------------------------------------
  // Pull-up wins when nobody drives, so a released pin never keeps old data
  assign pin_level_o = (drv_oe_i ? drv_i : 1'b1) & peer_pull_n_i;
endmodule // chap_host_model
`default_nettype wire

// ==== verification/test_card_host_address_status_pins.sv ====
// Self-checking testbench for the card host address and status pins
`timescale 1ns/10ps
`default_nettype none
module test_card_host_address_status_pins import chap_pkg::*;;
  // ----------------------------------------
  // Stimulus and wiring
  // ----------------------------------------
  logic clk = 1'b0;
  logic rst_b_n = 1'b0;
  logic [1:0] mode = 2'h0;
  logic [10:0] addr = 11'h000;
  logic attr_n = 1'b1, ce_lo_n = 1'b1, ce_hi_n = 1'b1;
  logic ready = 1'b0, wp = 1'b0, diag = 1'b0, peer_n = 1'b1;
  logic [7:0] csr = 8'h00;
  logic pin, pin_o, pin_oe, pass_diag_n, batt_two, batt_two_oe, warn, lane;
  logic [2:0] sel;
  logic [10:0] raddr;
  int num_errors = 0;
  int cmp_count = 0;
  always #25 clk = ~clk;
  chap_top DUT (.core_clk_i(clk), .rst_b_i(rst_b_n), .mode_i(mode),
    .addr_i(addr), .attr_sel_n_i(attr_n),
    .chip_enable_low_byte_n_i(ce_lo_n), .chip_enable_high_byte_n_i(ce_hi_n),
    .ready_i(ready), .write_protect_i(wp), .card_csr_i(csr),
    .pass_diag_drive_i(diag), .status_pin_i(pin), .reg_sel_o(sel),
    .reg_addr_o(raddr), .word_odd_warn_o(warn), .byte_lane_low_only_o(lane),
    .status_pin_o(pin_o), .status_pin_oe_o(pin_oe),
    .pass_diagnostic_n_o(pass_diag_n), .battery_volt_detect_two_o(batt_two),
    .battery_volt_detect_two_oe_o(batt_two_oe));
  chap_host_model host (.drv_i(pin_o), .drv_oe_i(pin_oe),
    .peer_pull_n_i(peer_n), .pin_level_o(pin));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic chk(input string what, input logic [10:0] exp,
                     input logic [10:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Pins need three edges to reach the registered outputs
  task automatic dec(input logic [1:0] m, input logic a_n,
                     input logic [10:0] a, input logic [2:0] s,
                     input logic [10:0] ra);
    mode = m;
    attr_n = a_n;
    addr = a;
    ce_lo_n = 1'b0;
    step(4);
    chk("reg_sel", {8'h00, s}, {8'h00, sel});
    chk("reg_addr", ra, raddr);
  endtask
  task automatic complete_run;
    $display("Comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_card_decode;
    dec(CHAP_MODE_MEMORY, 1'b0, 11'h1FF, CHAP_SEL_CIS, 11'h1FF);
    dec(CHAP_MODE_MEMORY, 1'b0, 11'h200, CHAP_SEL_CONFIG, 11'h200);
    dec(CHAP_MODE_MEMORY, 1'b1, 11'h7FE, CHAP_SEL_MEM_PORT, 11'h7FE);
    dec(CHAP_MODE_IO, 1'b0, 11'h3FE, CHAP_SEL_CONFIG, 11'h3FE);
    dec(CHAP_MODE_IO, 1'b1, 11'h00E, CHAP_SEL_IO_PORT, 11'h00E);
    ce_lo_n = 1'b1;
    step(4);
    chk("reg_sel idle", 11'h000, {8'h00, sel});
    $display("t_card_decode done");
  endtask
  task automatic t_odd_word;
    mode = CHAP_MODE_MEMORY;
    ce_lo_n = 1'b0;
    ce_hi_n = 1'b0;
    addr = 11'h001;
    step(4);
    chk("word_odd_warn", 11'h001, {10'h000, warn});
    addr = 11'h000;
    step(4);
    chk("word_odd_warn even", 11'h000, {10'h000, warn});
    chk("byte_lane_low card", 11'h000, {10'h000, lane});
    ce_hi_n = 1'b1;
    $display("t_odd_word done");
  endtask
  task automatic t_disk;
    dec(CHAP_MODE_DISK, 1'b1, 11'h005, CHAP_SEL_TASK_FILE, 11'h005);
    chk("byte_lane_low", 11'h001, {10'h000, lane});
    // Upper lines broken on purpose: they must still be ignored
    dec(CHAP_MODE_DISK, 1'b1, 11'h7FA, CHAP_SEL_TASK_FILE, 11'h002);
    $display("t_disk done");
  endtask
  task automatic t_fixed;
    mode = CHAP_MODE_MEMORY;
    step(4);
    chk("batt one level", 11'h003, {9'h000, pin_oe, pin_o});
    chk("batt two level", 11'h003, {9'h000, batt_two_oe, batt_two});
    $display("t_fixed done");
  endtask
  task automatic t_alert(input logic en, input int exp);
    int lows;
    mode = CHAP_MODE_IO;
    csr = en ? 8'(1 << CHAP_CSR_ALERT_EN_BIT) : 8'h00;
    step(4);
    for (int k = 0; k < 2; k++) begin
      if (k == 0) begin
        ready = ~ready;
      end else begin
        wp = ~wp;
      end
      lows = 0;
      repeat (8) begin
        step(1);
        if (pin_o !== 1'b1) lows++;
      end
      chk("alert pulses", 11'(exp), 11'(lows));
    end
    $display("t_alert done");
  endtask
  task automatic t_diag;
    mode = CHAP_MODE_DISK;
    diag = 1'b1;
    step(4);
    chk("pass diag drive", 11'h002, {9'h000, pin_oe, pin});
    diag = 1'b0;
    peer_n = 1'b0;
    step(4);
    chk("pass diag peer low", 11'h000, {10'h000, pass_diag_n});
    peer_n = 1'b1;
    step(4);
    chk("pass diag released", 11'h001, {10'h000, pass_diag_n});
    $display("t_diag done");
  endtask
  // ----------------------------------------
  // Main sequence and hang guard
  // ----------------------------------------
  initial begin
    step(6);
    rst_b_n = 1'b1;
    step(2);
    t_card_decode();
    t_odd_word();
    t_disk();
    t_fixed();
    t_alert(1'b1, 1);
    t_alert(1'b0, 0);
    t_diag();
    complete_run();
  end
  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    $display("[FAIL] run length expected finish seen hang");
    complete_run();
  end
endmodule // test_card_host_address_status_pins
`default_nettype wire
